// ===== brb_pkg.sv
// Purpose: Shared constants and types of the battery-backed BCD calendar block.
// Assumes: Byte addresses on an 8-bit register port with 32-bit data.
// Notes: The counting clock nominally delivers 32768 pulses per second.
package brb_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets.
  localparam logic [7:0] OFS_TIME = 8'h00;
  localparam logic [7:0] OFS_DATE = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_ALRM_A = 8'h0c;
  localparam logic [7:0] OFS_ALRM_B = 8'h10;
  localparam logic [7:0] OFS_SHIFT = 8'h14;
  localparam logic [7:0] OFS_CALIB = 8'h18;
  localparam logic [7:0] OFS_WAKEUP = 8'h1c;
  localparam logic [7:0] OFS_TS_TIME = 8'h20;
  localparam logic [7:0] OFS_TS_DATE = 8'h24;
  localparam logic [7:0] OFS_STATUS = 8'h28;
  localparam logic [7:0] OFS_MASK = 8'h2c;
  localparam logic [7:0] OFS_SUBSEC = 8'h30;
  localparam logic [7:0] OFS_BACKUP = 8'h40;
  localparam logic [7:0] BACKUP_BYTES = 8'h50;
  localparam int NUM_BACKUP = 20;

  // Time and date field positions.
  localparam int F_SEC = 0;
  localparam int F_MIN = 8;
  localparam int F_HOUR = 16;
  localparam int F_PM = 22;
  localparam int F_DAY = 0;
  localparam int F_MONTH = 8;
  localparam int F_WDAY = 13;
  localparam int F_YEAR = 16;

  // Alarm field ignore bits.
  localparam int ALRM_IGN_SEC = 24;
  localparam int ALRM_IGN_MIN = 25;
  localparam int ALRM_IGN_HOUR = 26;

  // Control register bits.
  localparam int CTRL_FMT12 = 0;
  localparam int CTRL_REF_EN = 1;
  localparam int CTRL_REF_60 = 2;
  localparam int CTRL_WAKE_EN = 3;
  localparam int CTRL_ALRM_EN = 4;
  localparam int CTRL_TS_EN = 6;
  localparam int CTRL_TAMP_EDGE = 7;
  localparam int CTRL_CLK_SEL = 8;
  localparam int CTRL_WAKE_RES = 10;
  localparam int CTRL_TAMP_FLT = 14;

  // Status and mask bits.
  localparam int ST_ALRM = 0;
  localparam int ST_WAKE = 2;
  localparam int ST_TS = 3;
  localparam int ST_TAMP = 4;
  localparam int NUM_EVENTS = 5;

  // Shift, calibration and wakeup fields.
  localparam int SHIFT_ADD1S = 31;
  localparam int SHIFT_W = 15;
  localparam int CALIB_PLUS = 9;
  localparam int CALIB_W = 9;
  localparam int WAKE_W = 17;

  // Synchronised pin indices.
  localparam int PIN_LSC = 0;
  localparam int PIN_RC1 = 1;
  localparam int PIN_RC2 = 2;
  localparam int PIN_HSC = 3;
  localparam int PIN_REF = 4;
  localparam int PIN_TAMP = 5;
  localparam int PIN_TS = 6;
  localparam int PIN_BATT = 7;
  localparam int PIN_SHDN = 8;
  localparam int PIN_LOWP = 9;
  localparam int NUM_PINS = 10;

  // Reset values and timing counts.
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [23:0] DATE_RST = 24'h00_2101;
  localparam logic [4:0] HSC_DIV_LAST = 5'h1f;
  localparam logic [5:0] REF_50_LAST = 6'h31;
  localparam logic [5:0] REF_60_LAST = 6'h3b;
  localparam logic [10:0] CALIB_INS_SLOT = 11'h400;

  typedef enum logic [1:0] {SRC_LSC, SRC_RC1, SRC_RC2, SRC_HSC} brb_clk_src_type;

endpackage : brb_pkg

// ===== brb_sync.sv
// Purpose: Two-flip-flop synchroniser for asynchronous pins.
// Assumes: Each bit is an independent level.
// Notes: The first stage is read only by the second stage.
`timescale 1ns/1ps
module brb_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Levels
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  for (genvar i = 0; i < W; i++)
  begin : g_bit
    always_ff @(posedge ref_clk_i)
    begin
      if (rst_i)
      begin
        meta_q[i] <= 1'b0;
        q_o[i] <= 1'b0;
      end
      else
      begin
        meta_q[i] <= d_i[i];
        q_o[i] <= meta_q[i];
      end
    end
  end
endmodule : brb_sync

// ===== brb_bcd_step.sv
// Purpose: One two-digit BCD counter stage with programmable first and last value.
// Assumes: The value is legal BCD.
// Notes: Purely combinational; the caller holds the register.
`timescale 1ns/1ps
module brb_bcd_step (
  // Current value and limits
  input wire logic [7:0] val_i,
  input wire logic [7:0] first_i,
  input wire logic [7:0] last_i,
  input wire logic step_i,
  // Next value and wrap
  output logic [7:0] next_o,
  output logic carry_o
);
  wire at_last = (val_i == last_i);
  wire ones_nine = (val_i[3:0] == 4'h9);
  wire [3:0] tens_inc = val_i[7:4] + 4'h1;
  wire [3:0] ones_inc = val_i[3:0] + 4'h1;
  wire [7:0] inc = ones_nine ? {tens_inc, 4'h0} : {val_i[7:4], ones_inc};

  assign carry_o = step_i & at_last;
  assign next_o = !step_i ? val_i : (at_last ? first_i : inc);
endmodule : brb_bcd_step

// ===== brb_rtc.sv
// Purpose: Battery-backed BCD calendar with alarms, timers, tamper and backup storage.
// Assumes: Counting clocks arrive as pins and are sampled by the 250 MHz system clock.
// Notes: Backup storage has no reset so it survives every reset of this block.
//
// What this block does
// - Keeps binary subsecond and BCD second, minute, hour, weekday, date, month, year; 12/24h.
// - Date rolls after 28/29/30/31 days, February following leap years.
// - Two independent programmable alarms compared against the running calendar.
// - On-the-fly shift removes 1 to 32767 counting pulses or adds a second.
// - With reference enabled, a 50 or 60 Hz input paces the seconds.
// - Digital calibration adds or removes counting pulses in 0.95 ppm steps.
// - One tamper input passes a programmable filter and raises a tamper event.
// - Calendar is captured on timestamp pin, tamper event or battery switchover.
// - 17-bit auto-reload wakeup down-counter with programmable resolution and period.
// - Twenty 32-bit backup registers, eighty bytes, writable by software.
// - Backup registers are never cleared by any reset or wakeup.
// - Counting clock chosen from crystal, two RC oscillators, or fast crystal over 32.
// - Crystal keeps counting always; RC sources stop in battery mode and shutdown.
// - Alarm, wakeup, timestamp and tamper events raise interrupt; wakeup only while the low-power pin is high.
`timescale 1ns/1ps
module brb_rtc
  import brb_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wr_data_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  output logic [DATA_W-1:0] rd_data_o,
  // Counting clock sources
  input wire logic low_speed_crystal_clock_i,
  input wire logic internal_rc_clock_one_i,
  input wire logic internal_rc_clock_two_i,
  input wire logic high_speed_crystal_clock_i,
  // Event and power pins
  input wire logic ref_50_60_i,
  input wire logic tamper_i,
  input wire logic timestamp_i,
  input wire logic battery_mode_i,
  input wire logic shutdown_i,
  input wire logic low_power_i,
  // Event outputs
  output logic irq_o,
  output logic wakeup_o
);
  logic [NUM_PINS-1:0] pins_s;
  logic [NUM_PINS-1:0] pins_prev_q;
  logic [31:0] ctrl_q;
  logic [31:0] alarm_q [2];
  logic [CALIB_W:0] calib_q;
  logic [WAKE_W-1:0] wake_reload_q;
  logic [NUM_EVENTS-1:0] status_q;
  logic [NUM_EVENTS-1:0] mask_q;
  logic [31:0] backup_q [NUM_BACKUP];
  logic [4:0] hsc_div_q;
  logic [19:0] cal_win_q;
  logic [SHIFT_W-1:0] shift_left_q;
  logic add_sec_q;
  logic [14:0] subsec_q;
  logic [5:0] ref_cnt_q;
  logic [7:0] sec_q;
  logic [7:0] min_q;
  logic [7:0] hour_q;
  logic pm_q;
  logic [2:0] wday_q;
  logic [7:0] day_q;
  logic [7:0] month_q;
  logic [7:0] year_q;
  logic sec_tick_q;
  logic [3:0] tamp_cnt_q;
  logic [23:0] ts_time_q;
  logic [23:0] ts_date_q;
  logic [15:0] wk_pre_q;
  logic [WAKE_W-1:0] wk_cnt_q;
  logic [NUM_EVENTS-1:0] alarm_ev;

  brb_sync #(
    .W(NUM_PINS)
  ) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .d_i({low_power_i, shutdown_i, battery_mode_i, timestamp_i, tamper_i, ref_50_60_i,
          high_speed_crystal_clock_i, internal_rc_clock_two_i, internal_rc_clock_one_i,
          low_speed_crystal_clock_i}),
    .q_o(pins_s)
  );

  wire [NUM_PINS-1:0] pin_rise = pins_s & ~pins_prev_q;
  wire batt = pins_s[PIN_BATT];
  wire shdn = pins_s[PIN_SHDN];

  // Register decode.
  wire wr_time = wr_en_i && (addr_i == OFS_TIME);
  wire wr_date = wr_en_i && (addr_i == OFS_DATE);
  wire wr_shift = wr_en_i && (addr_i == OFS_SHIFT);
  wire rd_status = rd_en_i && (addr_i == OFS_STATUS);
  wire [7:0] bk_off = addr_i - OFS_BACKUP;
  wire bk_hit = (addr_i >= OFS_BACKUP) && (bk_off < BACKUP_BYTES) && (addr_i[1:0] == 2'h0);
  wire [4:0] bk_idx = bk_off[6:2];

  // Counting clock selection; the fast crystal is divided by 32 first.
  wire [1:0] clk_sel_bits = ctrl_q[CTRL_CLK_SEL +: 2];
  wire brb_clk_src_type clk_sel = brb_clk_src_type'(clk_sel_bits);
  wire hsc_tick = pin_rise[PIN_HSC] && (hsc_div_q == HSC_DIV_LAST);
  logic src_rise;
  logic src_alive;

  always_comb
  begin
    unique case (clk_sel)
      SRC_LSC:
      begin
        src_rise = pin_rise[PIN_LSC];
        src_alive = 1'b1;
      end
      SRC_RC1:
      begin
        src_rise = pin_rise[PIN_RC1];
        src_alive = !batt && !shdn;
      end
      SRC_RC2:
      begin
        src_rise = pin_rise[PIN_RC2];
        src_alive = !batt && !shdn;
      end
      SRC_HSC:
      begin
        // The fast crystal has no battery supply, so it stops like the RC sources.
        src_rise = hsc_tick;
        src_alive = !batt && !shdn;
      end
    endcase
  end

  wire raw_tick = src_rise && src_alive;

  // Calibration over a 2^20 pulse window: up to 511 pulses removed, 512 inserted.
  wire cal_slot = (cal_win_q[10:0] == 11'h000) && (cal_win_q[19:11] < calib_q[CALIB_W-1:0]);
  wire cal_drop = raw_tick && cal_slot;
  wire cal_ins = raw_tick && calib_q[CALIB_PLUS] && (cal_win_q[10:0] == CALIB_INS_SLOT);
  wire shift_eat = raw_tick && !cal_drop && (shift_left_q != '0);
  logic [1:0] cnt_step;
  assign cnt_step = (!raw_tick || cal_drop || shift_eat) ? 2'h0 : (cal_ins ? 2'h2 : 2'h1);
  wire [15:0] ss_sum = {1'b0, subsec_q} + {14'h0, cnt_step};

  // Reference pacing: the prescaler only supplies subseconds while enabled.
  wire ref_en = ctrl_q[CTRL_REF_EN];
  wire [5:0] ref_last = ctrl_q[CTRL_REF_60] ? REF_60_LAST : REF_50_LAST;
  wire ref_sec = pin_rise[PIN_REF] && (ref_cnt_q == ref_last);
  wire sec_tick = (ref_en ? ref_sec : ss_sum[15]) || add_sec_q;

  // Calendar chain.
  wire fmt12 = ctrl_q[CTRL_FMT12];
  logic [7:0] sec_n, min_n, hour_n, day_n, month_n, year_n;
  logic sec_c, min_c, hour_c, day_c, month_c;
  logic [7:0] month_len;
  wire leap = year_q[4] ? (year_q[3:0] == 4'h2 || year_q[3:0] == 4'h6)
                        : (year_q[3:0] == 4'h0 || year_q[3:0] == 4'h4 || year_q[3:0] == 4'h8);

  always_comb
  begin
    unique case (month_q)
      8'h02: month_len = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: month_len = 8'h30;
      default: month_len = 8'h31;
    endcase
  end

  wire hour_eleven = (hour_q == 8'h11);
  wire pm_flip = fmt12 && min_c && hour_eleven;
  wire day_step = fmt12 ? (pm_flip && pm_q) : hour_c;
  wire [2:0] wday_n = !day_step ? wday_q : ((wday_q == 3'h7) ? 3'h1 : wday_q + 3'h1);

  brb_bcd_step u_sec (.val_i(sec_q), .first_i(8'h00), .last_i(8'h59), .step_i(sec_tick),
                      .next_o(sec_n), .carry_o(sec_c));
  brb_bcd_step u_min (.val_i(min_q), .first_i(8'h00), .last_i(8'h59), .step_i(sec_c),
                      .next_o(min_n), .carry_o(min_c));
  brb_bcd_step u_hour (.val_i(hour_q), .first_i(fmt12 ? 8'h01 : 8'h00),
                       .last_i(fmt12 ? 8'h12 : 8'h23), .step_i(min_c),
                       .next_o(hour_n), .carry_o(hour_c));
  brb_bcd_step u_day (.val_i(day_q), .first_i(8'h01), .last_i(month_len), .step_i(day_step),
                      .next_o(day_n), .carry_o(day_c));
  brb_bcd_step u_month (.val_i(month_q), .first_i(8'h01), .last_i(8'h12), .step_i(day_c),
                        .next_o(month_n), .carry_o(month_c));
  brb_bcd_step u_year (.val_i(year_q), .first_i(8'h00), .last_i(8'h99), .step_i(month_c),
                       .next_o(year_n), .carry_o());

  wire [23:0] time_now = {1'b0, pm_q, hour_q[5:0], min_q, sec_q};
  wire [23:0] date_now = {year_q, wday_q, month_q[4:0], day_q};

  // Alarms are checked once, the cycle after each second has been counted.
  for (genvar a = 0; a < 2; a++)
  begin : g_alarm
    wire [31:0] al = alarm_q[a];
    wire sec_ok = al[ALRM_IGN_SEC] || (al[F_SEC +: 8] == sec_q);
    wire min_ok = al[ALRM_IGN_MIN] || (al[F_MIN +: 8] == min_q);
    wire hour_ok = al[ALRM_IGN_HOUR] ||
                   ((al[F_HOUR +: 6] == hour_q[5:0]) && (!fmt12 || al[F_PM] == pm_q));
    assign alarm_ev[ST_ALRM + a] = ctrl_q[CTRL_ALRM_EN + a] && sec_tick_q &&
                                   sec_ok && min_ok && hour_ok;
  end

  // Tamper: edge mode, or a level held for 1, 2, 4 or 8 counting pulses.
  wire [1:0] tamp_flt = ctrl_q[CTRL_TAMP_FLT +: 2];
  wire [3:0] tamp_target = 4'h1 << tamp_flt;
  wire tamp_hi = pins_s[PIN_TAMP];
  wire tamp_lvl_ev = raw_tick && tamp_hi && (tamp_cnt_q == tamp_target - 4'h1);
  wire tamp_ev = ctrl_q[CTRL_TAMP_EDGE] ? pin_rise[PIN_TAMP] : tamp_lvl_ev;

  wire ts_ev = ctrl_q[CTRL_TS_EN] &&
               (pin_rise[PIN_TS] || tamp_ev || pin_rise[PIN_BATT]);

  // Wakeup timer steps once per 2^res counting pulses.
  wire [3:0] wk_res = ctrl_q[CTRL_WAKE_RES +: 4];
  wire [15:0] wk_mask = ~(16'hffff << wk_res);
  wire wk_step = raw_tick && ((wk_pre_q & wk_mask) == wk_mask);
  wire wk_en = ctrl_q[CTRL_WAKE_EN];
  wire wk_ev = wk_en && wk_step && (wk_cnt_q == '0);

  assign alarm_ev[ST_WAKE] = wk_ev;
  assign alarm_ev[ST_TS] = ts_ev;
  assign alarm_ev[ST_TAMP] = tamp_ev;

  // A new event in the clearing read's cycle survives the clear.
  wire [NUM_EVENTS-1:0] status_d = (rd_status ? '0 : status_q) | alarm_ev;
  wire irq_d = |(status_q & mask_q);

  // Read data selection; unmapped addresses read as zero.
  wire [31:0] rd_data_d =
    (addr_i == OFS_TIME) ? {8'h00, time_now} :
    (addr_i == OFS_DATE) ? {8'h00, date_now} :
    (addr_i == OFS_CTRL) ? ctrl_q :
    (addr_i == OFS_ALRM_A) ? alarm_q[0] :
    (addr_i == OFS_ALRM_B) ? alarm_q[1] :
    (addr_i == OFS_SHIFT) ? {add_sec_q, 16'h0000, shift_left_q} :
    (addr_i == OFS_CALIB) ? {22'h0, calib_q} :
    (addr_i == OFS_WAKEUP) ? {15'h0, wake_reload_q} :
    (addr_i == OFS_TS_TIME) ? {8'h00, ts_time_q} :
    (addr_i == OFS_TS_DATE) ? {8'h00, ts_date_q} :
    (addr_i == OFS_STATUS) ? {27'h0, status_q} :
    (addr_i == OFS_MASK) ? {27'h0, mask_q} :
    (addr_i == OFS_SUBSEC) ? {17'h0, subsec_q} :
    bk_hit ? backup_q[bk_idx] : 32'h0;

  // Software-written configuration.
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      ctrl_q <= CTRL_RST;
      alarm_q[0] <= '0;
      alarm_q[1] <= '0;
      calib_q <= '0;
      wake_reload_q <= '0;
      mask_q <= '0;
    end
    else if (wr_en_i)
    begin
      if (addr_i == OFS_CTRL) ctrl_q <= wr_data_i;
      if (addr_i == OFS_ALRM_A) alarm_q[0] <= wr_data_i;
      if (addr_i == OFS_ALRM_B) alarm_q[1] <= wr_data_i;
      if (addr_i == OFS_CALIB) calib_q <= wr_data_i[CALIB_W:0];
      if (addr_i == OFS_WAKEUP) wake_reload_q <= wr_data_i[WAKE_W-1:0];
      if (addr_i == OFS_MASK) mask_q <= wr_data_i[NUM_EVENTS-1:0];
    end
  end

  // Backup storage has no reset branch on purpose.
  always_ff @(posedge ref_clk_i)
  begin
    if (wr_en_i && bk_hit)
      backup_q[bk_idx] <= wr_data_i;
  end

  // Prescaling, calibration and shift.
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      pins_prev_q <= '0;
      hsc_div_q <= '0;
      cal_win_q <= '0;
      shift_left_q <= '0;
      add_sec_q <= 1'b0;
      subsec_q <= '0;
      ref_cnt_q <= '0;
      sec_tick_q <= 1'b0;
    end
    else
    begin
      pins_prev_q <= pins_s;
      sec_tick_q <= sec_tick;
      if (pin_rise[PIN_HSC]) hsc_div_q <= hsc_div_q + 5'h1;
      if (raw_tick) cal_win_q <= cal_win_q + 20'h1;
      if (wr_shift) shift_left_q <= wr_data_i[SHIFT_W-1:0];
      else if (shift_eat) shift_left_q <= shift_left_q - 15'h1;
      add_sec_q <= wr_shift && wr_data_i[SHIFT_ADD1S];
      if (wr_time || ref_sec) subsec_q <= '0;
      else subsec_q <= ss_sum[14:0];
      if (!ref_en || ref_sec) ref_cnt_q <= '0;
      else if (pin_rise[PIN_REF]) ref_cnt_q <= ref_cnt_q + 6'h1;
    end
  end

  // Calendar registers; a software write wins over counting.
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      {pm_q, hour_q, min_q, sec_q} <= '0;
      {year_q, wday_q, month_q, day_q} <= {DATE_RST[23:13], 3'h0, DATE_RST[12:0]};
    end
    else
    begin
      if (wr_time)
      begin
        sec_q <= wr_data_i[F_SEC +: 8];
        min_q <= wr_data_i[F_MIN +: 8];
        hour_q <= {2'h0, wr_data_i[F_HOUR +: 6]};
        pm_q <= wr_data_i[F_PM];
      end
      else
      begin
        sec_q <= sec_n;
        min_q <= min_n;
        hour_q <= hour_n;
        pm_q <= pm_q ^ pm_flip;
      end
      if (wr_date)
      begin
        day_q <= wr_data_i[F_DAY +: 8];
        month_q <= {3'h0, wr_data_i[F_MONTH +: 5]};
        wday_q <= wr_data_i[F_WDAY +: 3];
        year_q <= wr_data_i[F_YEAR +: 8];
      end
      else
      begin
        day_q <= day_n;
        month_q <= month_n;
        wday_q <= wday_n;
        year_q <= year_n;
      end
    end
  end

  // Tamper filter, timestamp capture and wakeup timer.
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      tamp_cnt_q <= '0;
      ts_time_q <= '0;
      ts_date_q <= '0;
      wk_pre_q <= '0;
      wk_cnt_q <= '0;
    end
    else
    begin
      if (!tamp_hi) tamp_cnt_q <= '0;
      else if (raw_tick && tamp_cnt_q != tamp_target) tamp_cnt_q <= tamp_cnt_q + 4'h1;
      if (ts_ev)
      begin
        ts_time_q <= time_now;
        ts_date_q <= date_now;
      end
      if (raw_tick) wk_pre_q <= wk_pre_q + 16'h1;
      if (!wk_en || wk_ev) wk_cnt_q <= wake_reload_q;
      else if (wk_step) wk_cnt_q <= wk_cnt_q - 17'h1;
    end
  end

  // Status and outputs.
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      status_q <= '0;
      irq_o <= 1'b0;
      wakeup_o <= 1'b0;
      rd_data_o <= '0;
    end
    else
    begin
      status_q <= status_d;
      irq_o <= irq_d;
      wakeup_o <= irq_d && pins_s[PIN_LOWP];
      rd_data_o <= rd_en_i ? rd_data_d : 32'h0;
    end
  end
endmodule : brb_rtc

// ===== brb_rtc_properties.sv
// Purpose: Port-level checks of the battery-backed calendar block.
// Assumes: Register reads answer only in the cycle after the strobe.
// Notes: The backup shadow has no reset, like the storage that it mirrors.
`timescale 1ns/1ps
module brb_rtc_properties
  import brb_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wr_data_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [DATA_W-1:0] rd_data_o,
  // Events
  input wire logic low_power_i,
  input wire logic irq_o,
  input wire logic wakeup_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  logic [DATA_W-1:0] bk0_q;
  logic bk0_ok_q = 1'b0;
  logic [15:0] ctrl_q;
  logic [4:0] mask_q;
  wire wr_bk0 = wr_en_i && (addr_i == OFS_BACKUP);
  wire rd_hole = rd_en_i && (addr_i[1:0] != 2'h0 || addr_i >= 8'h90
                 || (addr_i >= 8'h34 && addr_i < OFS_BACKUP));
  wire rd_time = rd_en_i && (addr_i == OFS_TIME);
  wire rd_date = rd_en_i && (addr_i == OFS_DATE);
  wire rd_bk0 = rd_en_i && (addr_i == OFS_BACKUP) && bk0_ok_q;
  wire rd_ctrl = rd_en_i && (addr_i == OFS_CTRL);
  wire rd_mask = rd_en_i && (addr_i == OFS_MASK);
  wire time_ok = (rd_data_o[3:0] < 4'ha) && (rd_data_o[6:4] < 3'h6)
                 && (rd_data_o[11:8] < 4'ha) && (rd_data_o[14:12] < 3'h6);
  wire date_ok = (rd_data_o[7:0] != 8'h00) && (rd_data_o[7:0] <= 8'h31)
                 && (rd_data_o[12:8] != 5'h00) && (rd_data_o[12:8] <= 5'h12);

  // The backup shadow must survive resets, so it only follows writes.
  always_ff @(posedge ref_clk_i)
  begin
    if (wr_bk0)
      bk0_q <= wr_data_i;
    bk0_ok_q <= bk0_ok_q | wr_bk0;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      ctrl_q <= 16'h0000;
      mask_q <= 5'h00;
    end
    else if (wr_en_i && addr_i == OFS_CTRL)
      ctrl_q <= wr_data_i[15:0];
    else if (wr_en_i && addr_i == OFS_MASK)
      mask_q <= wr_data_i[4:0];
  end

  a_read_idle_zero: assert property (!$past(rd_en_i) |-> rd_data_o == '0)
    else $error("read data not zero outside a read answer");
  a_unmapped_zero: assert property (rd_hole |=> rd_data_o == '0)
    else $error("unmapped read returned data");
  a_backup_keep: assert property (rd_bk0 |=> rd_data_o == bk0_q)
    else $error("backup word lost");
  a_ctrl_readback: assert property (rd_ctrl |=> rd_data_o[15:0] == ctrl_q)
    else $error("control readback wrong");
  a_mask_readback: assert property (rd_mask |=> rd_data_o[4:0] == mask_q)
    else $error("mask readback wrong");
  a_irq_masked: assert property ((mask_q == 5'h00) [*2] |-> !irq_o)
    else $error("interrupt with all events masked");
  a_wake_needs_irq: assert property (wakeup_o |-> irq_o)
    else $error("wakeup without interrupt condition");
  a_wake_lowp_only: assert property ((!low_power_i) [*4] |-> !wakeup_o)
    else $error("wakeup outside low power");
  a_quiet_after_reset: assert property ($past(rst_i) |-> !irq_o && !wakeup_o)
    else $error("event output high right after reset");
  a_time_bcd: assert property (rd_time |=> time_ok)
    else $error("time digits not BCD");
  a_date_legal: assert property (rd_date |=> date_ok)
    else $error("date field out of range");

  c_irq: cover property (irq_o && !wakeup_o);
  c_wake: cover property (wakeup_o);
  c_hole: cover property (rd_hole ##1 rd_data_o == '0);
endmodule : brb_rtc_properties

bind brb_rtc brb_rtc_properties i_brb_rtc_properties (.ref_clk_i, .rst_i, .addr_i, .wr_data_i,
  .wr_en_i, .rd_en_i, .rd_data_o, .low_power_i, .irq_o, .wakeup_o);

// ===== tb_brb_rtc.sv
// Purpose: Self-checking bench of the battery-backed calendar block.
// Assumes: Seconds are paced by the 50 Hz reference so that runs stay short.
// Notes: Tamper runs in edge mode; the RC pins stay idle and the fast crystal pin is pulsed.
`timescale 1ns/1ps
module tb_brb_rtc
  import brb_pkg::*;
;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wr_data_i = 32'h0;
  logic wr_en_i = 1'b0;
  logic rd_en_i = 1'b0;
  logic low_power_i = 1'b0;
  logic [5:0] pin_q = 6'h00;
  logic [31:0] rd_data_o;
  logic [31:0] rd_q;
  logic irq_o;
  logic wakeup_o;
  int n_fail = 0;
  int samples_checked = 0;

  brb_rtc i_brb_rtc (.ref_clk_i, .rst_i, .addr_i, .wr_data_i, .wr_en_i, .rd_en_i, .rd_data_o,
    .low_speed_crystal_clock_i(pin_q[0]), .internal_rc_clock_one_i(1'b0),
    .internal_rc_clock_two_i(1'b0), .high_speed_crystal_clock_i(pin_q[5]),
    .ref_50_60_i(pin_q[1]), .tamper_i(pin_q[3]), .timestamp_i(pin_q[2]),
    .battery_mode_i(pin_q[4]), .shutdown_i(1'b0), .low_power_i, .irq_o, .wakeup_o);

  initial
    forever #2 ref_clk_i = ~ref_clk_i;

  task automatic report_and_stop();
    $display("checked %0d, failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_en_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_en_i <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so sample just past that edge.
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_en_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_en_i <= 1'b0;
    #1 rd_q = rd_data_o;
    chk(rd_q, exp);
  endtask : rc

  // Each pin pulse is high for four cycles and repeats every nine, well clear of the two-stage synchroniser.
  task automatic pulse(input int b, input int n);
    repeat (n)
    begin
      @(posedge ref_clk_i);
      pin_q[b] <= 1'b1;
      repeat (4) @(posedge ref_clk_i);
      pin_q[b] <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
    end
  endtask : pulse

  task automatic do_reset();
    @(posedge ref_clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    rst_i <= 1'b0;
  endtask : do_reset

  initial
  begin
    repeat (100000) @(posedge ref_clk_i);
    n_fail++;
    report_and_stop();
  end

  initial
  begin
    repeat (3) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rc(OFS_TIME, 32'h0);
    rc(OFS_DATE, 32'h0000_2101);
    rc(OFS_CTRL, 32'h0);
    rc(8'h90, 32'h0);
    for (int i = 0; i < 20; i++)
      wr(OFS_BACKUP + 8'(4 * i), 32'hb0c0_0000 + 32'(i));
    do_reset();
    for (int i = 0; i < 20; i++)
      rc(OFS_BACKUP + 8'(4 * i), 32'hb0c0_0000 + 32'(i));
    wr(OFS_CTRL, 32'h2);
    for (int k = 0; k < 2; k++)
    begin
      wr(OFS_DATE, {8'h00, (k == 1) ? 8'h24 : 8'h23, 16'h6228});
      wr(OFS_TIME, 32'h0023_5959);
      pulse(1, 50);
      rc(OFS_TIME, 32'h0);
      rc(OFS_DATE, (k == 1) ? 32'h0024_8229 : 32'h0023_8301);
    end
    wr(OFS_CTRL, 32'h3);
    wr(OFS_TIME, 32'h0011_5959);
    pulse(1, 50);
    rc(OFS_TIME, 32'h0052_0000);
    for (int a = 0; a < 2; a++)
    begin
      wr(OFS_CTRL, 32'h2 | (32'h10 << a));
      wr(OFS_MASK, 32'h1 << a);
      wr(OFS_TIME, 32'h0010_2030);
      wr(OFS_ALRM_A + 8'(4 * a), 32'h0010_2031);
      pulse(1, 100);
      #1 chk({31'h0, irq_o}, 32'h1);
      rc(OFS_STATUS, 32'h1 << a);
      rc(OFS_STATUS, 32'h0);
      @(posedge ref_clk_i);
      #1 chk({31'h0, irq_o}, 32'h0);
    end
    wr(OFS_CTRL, 32'hc0);
    wr(OFS_MASK, 32'h18);
    wr(OFS_TIME, 32'h0008_0910);
    for (int j = 0; j < 3; j++)
    begin
      pulse(j + 2, 1);
      rc(OFS_STATUS, (j == 1) ? 32'h18 : 32'h8);
    end
    wr(OFS_TS_TIME, 32'h0);
    rc(OFS_TS_TIME, 32'h0008_0910);
    rc(OFS_TS_DATE, 32'h0024_8229);
    wr(OFS_WAKEUP, 32'h2);
    wr(OFS_MASK, 32'h4);
    wr(OFS_CTRL, 32'h8);
    rc(OFS_MASK, 32'h4);
    pulse(0, 2);
    rc(OFS_STATUS, 32'h0);
    pulse(0, 1);
    rc(OFS_STATUS, 32'h4);
    @(posedge ref_clk_i);
    low_power_i <= 1'b1;
    pulse(0, 3);
    #1 chk({31'h0, wakeup_o}, 32'h1);
    rc(OFS_STATUS, 32'h4);
    wr(OFS_TIME, 32'h0008_0910);
    wr(OFS_SHIFT, 32'h8000_0002);
    pulse(0, 3);
    rc(OFS_SUBSEC, 32'h1);
    rc(OFS_TIME, 32'h0008_0911);
    // A fresh reset starts the calibration window, so the first pulse falls in a drop slot.
    do_reset();
    wr(OFS_CALIB, 32'h1);
    pulse(0, 3);
    rc(OFS_SUBSEC, 32'h2);
    wr(OFS_CTRL, 32'h300);
    pulse(5, 32);
    rc(OFS_SUBSEC, 32'h3);
    @(posedge ref_clk_i);
    pin_q[4] <= 1'b1;
    pulse(5, 32);
    rc(OFS_SUBSEC, 32'h3);
    wr(OFS_CTRL, 32'h0);
    pulse(0, 1);
    rc(OFS_SUBSEC, 32'h4);
    report_and_stop();
  end
endmodule : tb_brb_rtc
